// ===== common/spdp_pkg.sv
// package: register map, sfr addresses, commands, states and carriers of the stack/pointer unit
package spdp_pkg;

  localparam int ADDR_W = 12;

  // axi4-lite register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SP = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_DPH = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_DPL = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_ACC = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_PC = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_DATA_POINTER = 12'h020;
  localparam logic [ADDR_W-1:0] RAM_BASE = 12'h400;

  // field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DIR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int FLAG_CY_BIT = 0;
  localparam int FLAG_AC_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;

  // direct addresses of the special-function bytes
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_ACC = 8'hE0;

  // reset values and decimal constants
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] BCD_FIX_LO = 9'h006;
  localparam logic [8:0] BCD_FIX_HI = 9'h060;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_DA, CMD_PUSH, CMD_POP, CMD_SCALL, CMD_LONG_CALL,
    CMD_RET, CMD_IRQ, CMD_INTERRUPT_EXIT, CMD_LDDP
  } spdp_cmd_e;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} spdp_fsm_e;

  // axi4-lite request channels from the master
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } spdp_axi_req_s;

  // axi4-lite answer channels from the slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spdp_axi_rsp_s;

  // whole state of the unit
  typedef struct packed {
    spdp_fsm_e fsm;
    spdp_cmd_e cmd;
    logic [7:0] dir;
    logic [15:0] imm;
    logic [7:0] sp;
    logic [7:0] data_pointer_high;
    logic [7:0] data_pointer_low;
    logic [7:0] acc;
    logic cy;
    logic ac;
    logic [15:0] pc;
    logic in_handler;
    logic [255:0][7:0] ram;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spdp_state_s;

endpackage : spdp_pkg

// ===== core/spdp_dec_adjust.sv
// decimal adjust of a packed decimal byte after addition
`timescale 1ns/1ns
module spdp_dec_adjust (
  input wire logic [7:0] value_in,
  input wire logic carry_in,
  input wire logic aux_carry_in,
  output logic [7:0] value_out,
  output logic carry_out
);
  import spdp_pkg::*;

  logic [8:0] lo_sum;
  logic [8:0] hi_sum;
  logic cy_mid;

  // low digit first, its carry can push the high digit out of range
  always_comb begin
    lo_sum = {1'b0, value_in};
    if ((value_in[3:0] > BCD_MAX) || aux_carry_in) begin
      lo_sum = {1'b0, value_in} + BCD_FIX_LO;
    end
    cy_mid = carry_in | lo_sum[8];
    hi_sum = {1'b0, lo_sum[7:0]};
    if ((lo_sum[7:4] > BCD_MAX) || cy_mid) begin
      hi_sum = {1'b0, lo_sum[7:0]} + BCD_FIX_HI;
    end
    value_out = hi_sum[7:0];
    carry_out = cy_mid | hi_sum[8]; // carry is only ever set, never cleared
  end

endmodule : spdp_dec_adjust

// ===== core/spdp_unit.sv
// stack pointer, internal ram stack, data pointer and decimal adjust with axi4-lite access
`timescale 1ns/1ns
module spdp_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire spdp_pkg::spdp_axi_req_s axi_req,
  output spdp_pkg::spdp_axi_rsp_s axi_rsp,
  output logic [15:0] data_pointer_addr,
  output logic [15:0] program_counter,
  output logic busy
);
  import spdp_pkg::*;

  spdp_state_s s_q;
  spdp_state_s s_d;
  logic [7:0] da_res;
  logic da_cy;
  logic aw_ok;
  logic w_ok;
  logic wr_go;

  // decimal adjust works on the live operand register and flags
  spdp_dec_adjust u_dec_adjust (
    .value_in(s_q.acc),
    .carry_in(s_q.cy),
    .aux_carry_in(s_q.ac),
    .value_out(da_res),
    .carry_out(da_cy)
  );

  // true for every offset that answers okay; used by the write and the read path
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (a >= RAM_BASE && a < RAM_BASE + 12'h400) begin
      hit = 1'b1;
    end else if (a <= OFF_DATA_POINTER) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : addr_known

  // direct-address read: low half is internal ram, upper half the sfr bytes
  function automatic logic [7:0] dir_read(input spdp_state_s st, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) begin
      v = st.ram[a];
    end else if (a == SFR_SP) begin
      v = st.sp;
    end else if (a == SFR_DPL) begin
      v = st.data_pointer_low;
    end else if (a == SFR_DPH) begin
      v = st.data_pointer_high;
    end else if (a == SFR_ACC) begin
      v = st.acc;
    end
    return v;
  endfunction : dir_read

  // register read mux for the bus
  function automatic logic [31:0] rd_word(input spdp_state_s st, input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a >= RAM_BASE && a < RAM_BASE + 12'h400) begin
      v[7:0] = st.ram[a[9:2]];
    end else if (a == OFF_CMD) begin
      v[CMD_OP_LSB +: 4] = st.cmd;
      v[CMD_DIR_LSB +: 8] = st.dir;
      v[CMD_IMM_LSB +: 16] = st.imm;
    end else if (a == OFF_STATUS) begin
      v[STAT_BUSY_BIT] = (st.fsm != ST_IDLE);
      v[STAT_IRQ_BIT] = st.in_handler;
    end else if (a == OFF_SP) begin
      v[7:0] = st.sp;
    end else if (a == OFF_DPH) begin
      v[7:0] = st.data_pointer_high;
    end else if (a == OFF_DPL) begin
      v[7:0] = st.data_pointer_low;
    end else if (a == OFF_ACC) begin
      v[7:0] = st.acc;
    end else if (a == OFF_FLAGS) begin
      v[FLAG_CY_BIT] = st.cy;
      v[FLAG_AC_BIT] = st.ac;
    end else if (a == OFF_PC) begin
      v[15:0] = st.pc;
    end else if (a == OFF_DATA_POINTER) begin
      v[15:0] = {st.data_pointer_high, st.data_pointer_low};
    end
    return v;
  endfunction : rd_word

  // writes stall while a command runs, so software cannot race the stack engine
  assign aw_ok = !s_q.aw_full && !s_q.bvalid && (s_q.fsm == ST_IDLE);
  assign w_ok = !s_q.w_full && !s_q.bvalid && (s_q.fsm == ST_IDLE);
  assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;

  // bus answers and outputs straight from state
  always_comb begin
    axi_rsp.awready = aw_ok;
    axi_rsp.wready = w_ok;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.arready = !s_q.rvalid;
    axi_rsp.rvalid = s_q.rvalid;
    axi_rsp.rdata = s_q.rdata;
    axi_rsp.rresp = s_q.rresp;
  end

  assign data_pointer_addr = {s_q.data_pointer_high, s_q.data_pointer_low};
  assign program_counter = s_q.pc;
  assign busy = (s_q.fsm != ST_IDLE);

  // next-state logic: bus slave, register writes and the stack engine
  always_comb begin
    logic [7:0] sp_inc;
    logic [7:0] sp_dec;
    logic [7:0] pop_val;
    logic [ADDR_W-1:0] wa;
    sp_inc = s_q.sp + 8'h01;
    sp_dec = s_q.sp - 8'h01;
    pop_val = s_q.ram[s_q.sp];
    wa = s_q.aw_addr;
    s_d = s_q;

    // write address and data are latched independently, in either order
    if (axi_req.awvalid && aw_ok) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && w_ok) begin
      s_d.w_full = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // both halves present: perform the write and raise the response
    if (wr_go) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_known(wa) ? RESP_OKAY : RESP_SLVERR;
      if (!addr_known(wa)) begin
        s_d.bresp = RESP_SLVERR;
      end else if (wa >= RAM_BASE) begin
        if (s_q.w_strb[0]) begin
          s_d.ram[wa[9:2]] = s_q.w_data[7:0];
        end
      end else if (wa == OFF_CMD) begin
        // a command needs all four lanes, a partial write cannot start one
        if (s_q.w_strb == 4'hF) begin
          s_d.cmd = spdp_cmd_e'(s_q.w_data[CMD_OP_LSB +: 4]);
          s_d.dir = s_q.w_data[CMD_DIR_LSB +: 8];
          s_d.imm = s_q.w_data[CMD_IMM_LSB +: 16];
          s_d.fsm = ST_EXEC;
        end
      end else if (wa == OFF_SP) begin
        if (s_q.w_strb[0]) begin
          s_d.sp = s_q.w_data[7:0];
        end
      end else if (wa == OFF_DPH) begin
        if (s_q.w_strb[0]) begin
          s_d.data_pointer_high = s_q.w_data[7:0];
        end
      end else if (wa == OFF_DPL) begin
        if (s_q.w_strb[0]) begin
          s_d.data_pointer_low = s_q.w_data[7:0];
        end
      end else if (wa == OFF_ACC) begin
        if (s_q.w_strb[0]) begin
          s_d.acc = s_q.w_data[7:0];
        end
      end else if (wa == OFF_FLAGS) begin
        if (s_q.w_strb[0]) begin
          s_d.cy = s_q.w_data[FLAG_CY_BIT];
          s_d.ac = s_q.w_data[FLAG_AC_BIT];
        end
      end else if (wa == OFF_PC) begin
        if (s_q.w_strb[0]) begin
          s_d.pc[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1]) begin
          s_d.pc[15:8] = s_q.w_data[15:8];
        end
      end
    end

    // read channel: one cycle from address to data
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word(s_q, axi_req.araddr);
      s_d.rresp = addr_known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // stack engine; stack slots are indexed by the 8-bit pointer, ram is also reached by direct operands and the bus window
    case (s_q.fsm)
      ST_EXEC: begin
        s_d.fsm = ST_IDLE;
        case (s_q.cmd)
          CMD_DA: begin
            s_d.acc = da_res;
            s_d.cy = da_cy;
          end
          CMD_PUSH: begin
            s_d.sp = sp_inc;
            s_d.ram[sp_inc] = dir_read(s_q, s_q.dir);
          end
          CMD_POP: begin
            s_d.sp = sp_dec;
            // destination write last, so popping into the pointer itself wins
            if (!s_q.dir[7]) begin
              s_d.ram[s_q.dir] = pop_val;
            end else if (s_q.dir == SFR_SP) begin
              s_d.sp = pop_val;
            end else if (s_q.dir == SFR_DPL) begin
              s_d.data_pointer_low = pop_val;
            end else if (s_q.dir == SFR_DPH) begin
              s_d.data_pointer_high = pop_val;
            end else if (s_q.dir == SFR_ACC) begin
              s_d.acc = pop_val;
            end
          end
          CMD_SCALL, CMD_LONG_CALL, CMD_IRQ: begin
            s_d.sp = sp_inc;
            s_d.ram[sp_inc] = s_q.pc[7:0];
            s_d.fsm = ST_SECOND;
          end
          CMD_RET, CMD_INTERRUPT_EXIT: begin
            s_d.pc[15:8] = pop_val;
            s_d.sp = sp_dec;
            s_d.fsm = ST_SECOND;
          end
          CMD_LDDP: begin
            s_d.data_pointer_high = s_q.imm[15:8];
            s_d.data_pointer_low = s_q.imm[7:0];
          end
          default: begin
          end
        endcase
      end
      ST_SECOND: begin
        s_d.fsm = ST_IDLE;
        if (s_q.cmd == CMD_RET || s_q.cmd == CMD_INTERRUPT_EXIT) begin
          s_d.pc[7:0] = pop_val;
          s_d.sp = sp_dec;
          if (s_q.cmd == CMD_INTERRUPT_EXIT) begin
            s_d.in_handler = 1'b0;
          end
        end else begin
          s_d.sp = sp_inc;
          s_d.ram[sp_inc] = s_q.pc[15:8];
          s_d.pc = s_q.imm; // jump to target or vector
          if (s_q.cmd == CMD_IRQ) begin
            s_d.in_handler = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // single state register; ram is cleared too so reads are never unknown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.sp <= SP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // helper signals for the checks below
  logic push_go;
  logic pop_go;
  logic call_go;
  logic da_go;
  logic lddp_go;
  logic [7:0] push_val;
  logic [7:0] top_val;
  logic [7:0] sp_next_w;
  assign push_go = (s_q.fsm == ST_EXEC) && (s_q.cmd == CMD_PUSH);
  assign pop_go = (s_q.fsm == ST_EXEC) && (s_q.cmd == CMD_POP);
  assign call_go = (s_q.fsm == ST_EXEC) && (s_q.cmd == CMD_LONG_CALL);
  assign da_go = (s_q.fsm == ST_EXEC) && (s_q.cmd == CMD_DA);
  assign lddp_go = (s_q.fsm == ST_EXEC) && (s_q.cmd == CMD_LDDP);
  assign push_val = dir_read(s_q, s_q.dir);
  assign top_val = s_q.ram[s_q.sp];
  assign sp_next_w = s_q.sp + 8'h01;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sp_reset;
    $rose(aresetn) |-> (s_q.sp == 8'h07);
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 07 after reset");

  property p_push;
    push_go && (s_q.dir != SFR_SP)
      |=> (s_q.sp == $past(sp_next_w)) && (s_q.ram[s_q.sp] == $past(push_val));
  endproperty
  a_push: assert property (p_push) else $error("push did not pre-increment and store");

  property p_pop;
    pop_go && (s_q.dir != SFR_SP) |=> (s_q.sp == $past(s_q.sp) - 8'h01);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not post-decrement");

  property p_pop_acc;
    pop_go && (s_q.dir == SFR_ACC) |=> (s_q.acc == $past(top_val));
  endproperty
  a_pop_acc: assert property (p_pop_acc) else $error("pop into operand lost the value");

  property p_wrap;
    push_go && (s_q.sp == 8'hFF) && (s_q.dir != SFR_SP) |=> (s_q.sp == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("stack pointer did not wrap");

  property p_call;
    call_go |-> ##2 (s_q.sp == $past(s_q.sp, 2) + 8'h02) && (s_q.fsm == ST_IDLE)
      && (s_q.ram[s_q.sp] == $past(s_q.pc[15:8], 2));
  endproperty
  a_call: assert property (p_call) else $error("call did not save two bytes");

  property p_lddp;
    lddp_go |=> (data_pointer_addr == $past(s_q.imm));
  endproperty
  a_lddp: assert property (p_lddp) else $error("pointer load did not set both bytes");

  property p_dph_alone;
    wr_go && (s_q.aw_addr == OFF_DPH) && (s_q.fsm == ST_IDLE) |=> $stable(s_q.data_pointer_low);
  endproperty
  a_dph_alone: assert property (p_dph_alone) else $error("high byte write changed low byte");

  property p_da_valid;
    da_go && !s_q.cy && !s_q.ac && (s_q.acc[3:0] <= 4'h9) && (s_q.acc[7:4] <= 4'h9)
      |=> $stable(s_q.acc) && !s_q.cy;
  endproperty
  a_da_valid: assert property (p_da_valid) else $error("adjust altered a valid value");

  property p_da_low;
    da_go && (s_q.acc[3:0] > 4'h9) |=> (s_q.acc[3:0] == $past(s_q.acc[3:0]) + 4'h6);
  endproperty
  a_da_low: assert property (p_da_low) else $error("low digit not corrected by six");

endmodule : spdp_unit

// ===== verification/tb_spdp_unit.sv
// self-checking bench for the stack pointer and data pointer unit
`timescale 1ns/1ns
module tb_spdp_unit;
  import spdp_pkg::*;

  logic aclk;
  logic aresetn;
  spdp_axi_req_s req;
  spdp_axi_rsp_s rsp;
  logic [15:0] dp_addr;
  logic [15:0] pc;
  logic busy;
  int errors;
  int num_checks;

  spdp_unit i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(req),
    .axi_rsp(rsp),
    .data_pointer_addr(dp_addr),
    .program_counter(pc),
    .busy(busy)
  );

  // 50 MHz core clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // single exit point of the run
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_data

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp

  task automatic hang();
    errors++;
    $display("[ERR] handshake expected done seen timeout");
    test_done();
  endtask : hang

  // ready is sampled at the falling edge, so the decision never races the rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] resp);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    resp = 2'h3;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      aw_hs = req.awvalid && rsp.awready;
      w_hs = req.wvalid && rsp.wready;
      b_hs = rsp.bvalid && req.bready;
      resp = rsp.bresp;
      @(posedge aclk);
      if (aw_hs) req.awvalid <= 1'b0;
      if (w_hs) req.wvalid <= 1'b0;
      if (b_hs) begin
        req.bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_hs;
    logic r_hs;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      ar_hs = req.arvalid && rsp.arready;
      r_hs = rsp.rvalid && req.rready;
      d = rsp.rdata;
      resp = rsp.rresp;
      @(posedge aclk);
      if (ar_hs) req.arvalid <= 1'b0;
      if (r_hs) begin
        req.rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axi_wr(a, d, s, r);
    chk_resp("bresp", RESP_OKAY, r);
  endtask : wr

  // read a register and compare it in one go
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_resp("rresp", RESP_OKAY, r);
    chk_data(what, exp, d);
  endtask : rd

  function automatic logic [11:0] ram_at(input logic [7:0] idx);
    return RAM_BASE + {2'h0, idx, 2'h0};
  endfunction : ram_at

  // reads issued while busy would see the state before execution, so wait it out
  task automatic cmd(input spdp_cmd_e op, input logic [7:0] dir, input logic [15:0] imm);
    wr(OFF_CMD, {imm, dir, 4'h0, op}, 4'hF);
    for (int n = 0; n < 20; n++) begin
      @(negedge aclk);
      if (busy === 1'b0) return;
    end
    hang();
  endtask : cmd

  task automatic t_reset();
    rd("stack_pointer", OFF_SP, 32'h0000_0007);
    rd("status", OFF_STATUS, 32'h0000_0000);
  endtask : t_reset

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(12'h0FC, d, r);
    chk_resp("rresp unmapped", RESP_SLVERR, r);
    axi_wr(12'h0FC, 32'h0000_00FF, 4'hF, r);
    chk_resp("bresp unmapped", RESP_SLVERR, r);
  endtask : t_unmapped

  // operand, flags in, result, carry out
  task automatic t_dec_adjust();
    logic [7:0] tbl [4][4];
    logic [31:0] d;
    logic [1:0] r;
    tbl = '{'{8'h5D, 8'h00, 8'h63, 8'h00}, '{8'h9A, 8'h00, 8'h00, 8'h01},
            '{8'h12, 8'h02, 8'h18, 8'h00}, '{8'h25, 8'h01, 8'h85, 8'h01}};
    foreach (tbl[i]) begin
      wr(OFF_ACC, {24'h0, tbl[i][0]}, 4'h1);
      wr(OFF_FLAGS, {24'h0, tbl[i][1]}, 4'h1);
      cmd(CMD_DA, 8'h00, 16'h0000);
      rd("decimal_adjust result", OFF_ACC, {24'h0, tbl[i][2]});
      // carry out of the high digit must land in the flag register
      axi_rd(OFF_FLAGS, d, r);
      chk_resp("rresp flags", RESP_OKAY, r);
      chk_data("decimal_adjust carry", {31'h0, tbl[i][3][0]}, {31'h0, d[FLAG_CY_BIT]});
      wr(OFF_FLAGS, 32'h0000_0000, 4'h1);
    end
  endtask : t_dec_adjust

  task automatic t_stack();
    for (int v = 4; v <= 6; v++) begin
      wr(OFF_ACC, v, 4'h1);
      cmd(CMD_PUSH, SFR_ACC, 16'h0000);
    end
    rd("stack_pointer after pushes", OFF_SP, 32'h0000_000A);
    rd("first stacked byte", ram_at(8'h08), 32'h0000_0004);
    for (int v = 6; v >= 4; v--) begin
      cmd(CMD_POP, 8'h40, 16'h0000);
      rd("popped byte", ram_at(8'h40), v);
    end
    rd("stack_pointer after pops", OFF_SP, 32'h0000_0007);
    cmd(CMD_PUSH, 8'h40, 16'h0000);
    cmd(CMD_POP, SFR_ACC, 16'h0000);
    rd("main_operand_reg popped", OFF_ACC, 32'h0000_0004);
  endtask : t_stack

  // no limit check: the pointer rolls over and the store lands at byte zero
  task automatic t_wrap();
    wr(OFF_SP, 32'h0000_00FF, 4'h1);
    wr(OFF_ACC, 32'h0000_005A, 4'h1);
    cmd(CMD_PUSH, SFR_ACC, 16'h0000);
    rd("stack_pointer wrapped", OFF_SP, 32'h0000_0000);
    rd("wrapped store", ram_at(8'h00), 32'h0000_005A);
    cmd(CMD_POP, 8'h41, 16'h0000);
    rd("stack_pointer unwrapped", OFF_SP, 32'h0000_00FF);
    wr(OFF_SP, 32'h0000_0007, 4'h1);
  endtask : t_wrap

  task automatic t_calls();
    spdp_cmd_e calls [3];
    spdp_cmd_e back;
    calls = '{CMD_SCALL, CMD_LONG_CALL, CMD_IRQ};
    foreach (calls[i]) begin
      back = (calls[i] == CMD_IRQ) ? CMD_INTERRUPT_EXIT : CMD_RET;
      wr(OFF_PC, 32'h0000_1234, 4'h3);
      cmd(calls[i], 8'h00, 16'hABCD);
      chk_data("program_counter call", 32'h0000_ABCD, {16'h0, pc});
      rd("stack_pointer call", OFF_SP, 32'h0000_0009);
      rd("return low", ram_at(8'h08), 32'h0000_0034);
      rd("return high", ram_at(8'h09), 32'h0000_0012);
      rd("status handler", OFF_STATUS, (calls[i] == CMD_IRQ) ? 32'h2 : 32'h0);
      cmd(back, 8'h00, 16'h0000);
      chk_data("program_counter exit", 32'h0000_1234, {16'h0, pc});
      rd("stack_pointer exit", OFF_SP, 32'h0000_0007);
      rd("status after exit", OFF_STATUS, 32'h0000_0000);
    end
  endtask : t_calls

  task automatic t_data_pointer();
    cmd(CMD_LDDP, 8'h00, 16'hF123);
    chk_data("data_pointer load", 32'h0000_F123, {16'h0, dp_addr});
    wr(OFF_DPH, 32'h0000_0040, 4'h1);
    chk_data("data_pointer high write", 32'h0000_4023, {16'h0, dp_addr});
    wr(OFF_DPL, 32'h0000_0056, 4'h1);
    chk_data("data_pointer low write", 32'h0000_4056, {16'h0, dp_addr});
    rd("data_pointer word", OFF_DATA_POINTER, 32'h0000_4056);
    cmd(CMD_PUSH, SFR_DPH, 16'h0000);
    cmd(CMD_POP, SFR_DPL, 16'h0000);
    chk_data("data_pointer via stack", 32'h0000_4040, {16'h0, dp_addr});
  endtask : t_data_pointer

  // main sequence: reset for three cycles, then every scenario in turn
  initial begin
    errors = 0;
    num_checks = 0;
    req = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_dec_adjust();
    t_stack();
    t_wrap();
    t_calls();
    t_data_pointer();
    test_done();
  end
endmodule : tb_spdp_unit
